/* ebps_map.vh */
// ebps_map.vh: register offsets, field positions and reset values of the
// external bus phase sequencer.
// assumes: included by the sequencer module; definitions only.
`ifndef EBPS_MAP_VH
`define EBPS_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define EBPS_OFS_CTRL 8'h00
`define EBPS_OFS_STATUS 8'h04
`define EBPS_OFS_RDATA 8'h08
`define EBPS_OFS_TCFG0 8'h10
`define EBPS_TCFG_STRIDE 8'h04

// ----------------------------------------
// control register fields
// ----------------------------------------
`define EBPS_CTRL_CLKDRV 0
`define EBPS_CTRL_RST 1'b1

// ----------------------------------------
// chip_select_timing_config fields
// ----------------------------------------
`define EBPS_TC_AB 0
`define EBPS_TC_ABX_LO 1
`define EBPS_TC_ABX_HI 2
`define EBPS_TC_C_LO 3
`define EBPS_TC_C_HI 4
`define EBPS_TC_D 5
`define EBPS_TC_E_LO 6
`define EBPS_TC_E_HI 10
`define EBPS_TC_F_LO 11
`define EBPS_TC_F_HI 12
`define EBPS_TC_RDYEN 13
`define EBPS_TC_RDYPOL 14
`define EBPS_TC_RDYASY 15
`define EBPS_TC_WIDTH 16
`define EBPS_TC_RST 16'h07df

`endif

/* ebps_sequencer.v */
// ebps_sequencer.v: five-phase external bus cycle sequencer with a
// classic wishbone register slave and per chip-select timing settings.
// assumes: core requests arrive on clk; bus pins and ready come from
// outside the clock domain; one phase time unit is one clk cycle.
//
// Functional notes
// (R01) cycle runs phases AB, C, D, E, F in order
// (R02) phase lengths from selected chip-select timing config
// (R03) address setup normally one or two units
// (R04) window change adds zero to three setup units
// (R05) command delay 0-3, write setup 0-1 units
// (R06) hold phase lasts zero to three units
// (R07) access 1-32 units, ready may stretch it
// (R08) reference clock output equals system clock
// (R09) read data captured when read strobe releases
// (R10) ready active level chosen by configuration
// (R11) asynchronous ready adds an extra synchroniser stage
// (R12) phase counter in one-clock phase time units
// (R13) zero-length phases skipped within same cycle
`timescale 1ns/1ps
`include "ebps_map.vh"

module ebps_sequencer #(
    parameter NUM_CS = 4,
    parameter CS_W = 2,
    parameter ADDR_W = 24,
    parameter DATA_W = 16
) (
    // clock, reset, enable
    input wire clk,
    input wire reset_n,
    input wire ce,
    // wishbone register slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // core request port
    input wire reqValid,
    output wire reqReady,
    input wire reqWrite,
    input wire [CS_W-1:0] reqCs,
    input wire [ADDR_W-1:0] reqAddr,
    input wire [DATA_W-1:0] reqWdata,
    output reg rspValid,
    output reg [DATA_W-1:0] rspRdata,
    // external bus pins
    output reg [ADDR_W-1:0] busAddr,
    output reg [DATA_W-1:0] busDataOut,
    output reg busDataOe,
    input wire [DATA_W-1:0] busDataIn,
    output reg [NUM_CS-1:0] busCs_n,
    output reg busAle,
    output reg busRd_n,
    output reg busWr_n,
    input wire busReady,
    output wire busRefClkOut,
    output reg extClkDrvEn
);

    // ----------------------------------------
    // phase codes
    // ----------------------------------------
    localparam [2:0] PH_IDLE = 3'h0;
    localparam [2:0] PH_AB = 3'h1;
    localparam [2:0] PH_C = 3'h2;
    localparam [2:0] PH_D = 3'h3;
    localparam [2:0] PH_E = 3'h4;
    localparam [2:0] PH_F = 3'h5;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    reg [`EBPS_TC_WIDTH-1:0] tcfg_r [0:NUM_CS-1]; // timing config per chip select
    reg [2:0] phase_r; // current phase
    reg [5:0] cnt_r; // units left in phase
    reg [CS_W-1:0] lastCs_r; // window of previous cycle
    reg [CS_W-1:0] curCs_r; // window of running cycle
    reg write_r; // running cycle is a write
    reg [DATA_W-1:0] rdata_r; // last captured read data
    reg [DATA_W-1:0] dinS1_r, dinS2_r; // read data synchroniser
    reg rdyS1_r, rdyS2_r, rdyS3_r; // ready synchroniser
    reg [2:0] phaseNxt;
    reg [5:0] cntNxt;
    reg capture; // read data taken this edge
    wire [`EBPS_TC_WIDTH-1:0] tc; // config of running cycle
    wire [`EBPS_TC_WIDTH-1:0] tcReq; // config of requested cycle
    wire [5:0] lenC, lenD, lenE, lenF;
    wire [5:0] lenAbReq;
    wire rdyRaw, rdyActive;
    wire wbReq;

    assign tc = tcfg_r[curCs_r];
    assign tcReq = tcfg_r[reqCs];

    // lengths in phase time units
    assign lenC = {4'h0, tc[`EBPS_TC_C_HI:`EBPS_TC_C_LO]}; // R05
    assign lenD = {5'h00, tc[`EBPS_TC_D]}; // R05
    assign lenE = {1'b0, tc[`EBPS_TC_E_HI:`EBPS_TC_E_LO]} + 6'h01; // R07
    assign lenF = {4'h0, tc[`EBPS_TC_F_HI:`EBPS_TC_F_LO]}; // R06
    // one or two units, plus extension on window change
    assign lenAbReq = {5'h00, tcReq[`EBPS_TC_AB]} + 6'h01 // R03
        + ((reqCs != lastCs_r) ? {4'h0, tcReq[`EBPS_TC_ABX_HI:`EBPS_TC_ABX_LO]} : 6'h00); // R04

    // reference clock is the system clock; the driver enable is software's
    assign busRefClkOut = clk; // R08

    // new request only when idle and running
    assign reqReady = ce && (phase_r == PH_IDLE);

    // ----------------------------------------
    // ready synchroniser
    // ----------------------------------------
    // two flops always; async mode reads a third stage
    always @(posedge clk) begin
        if (!reset_n) begin
            rdyS1_r <= 1'b0;
            rdyS2_r <= 1'b0;
            rdyS3_r <= 1'b0;
            dinS1_r <= {DATA_W{1'b0}};
            dinS2_r <= {DATA_W{1'b0}};
        end else if (ce) begin
            rdyS1_r <= busReady;
            rdyS2_r <= rdyS1_r;
            rdyS3_r <= rdyS2_r; // R11
            dinS1_r <= busDataIn;
            dinS2_r <= dinS1_r;
        end
    end

    assign rdyRaw = tc[`EBPS_TC_RDYASY] ? rdyS3_r : rdyS2_r; // R11
    assign rdyActive = (rdyRaw == tc[`EBPS_TC_RDYPOL]); // R10

    // ----------------------------------------
    // next phase and counter
    // ----------------------------------------
    // leaving a phase jumps past every zero-length phase at once
    always @* begin
        phaseNxt = phase_r;
        cntNxt = cnt_r;
        capture = 1'b0;
        case (phase_r)
            PH_IDLE: begin
                if (reqValid) begin
                    phaseNxt = PH_AB; // R01
                    cntNxt = lenAbReq; // R02
                end
            end
            PH_AB: begin
                if (cnt_r > 6'h01) begin
                    cntNxt = cnt_r - 6'h01; // R12
                end else if (lenC != 6'h00) begin
                    phaseNxt = PH_C;
                    cntNxt = lenC;
                end else if (lenD != 6'h00) begin
                    phaseNxt = PH_D; // R13
                    cntNxt = lenD;
                end else begin
                    phaseNxt = PH_E; // R13
                    cntNxt = lenE;
                end
            end
            PH_C: begin
                if (cnt_r > 6'h01) begin
                    cntNxt = cnt_r - 6'h01;
                end else if (lenD != 6'h00) begin
                    phaseNxt = PH_D;
                    cntNxt = lenD;
                end else begin
                    phaseNxt = PH_E; // R13
                    cntNxt = lenE;
                end
            end
            PH_D: begin
                phaseNxt = PH_E;
                cntNxt = lenE;
            end
            PH_E: begin
                if (cnt_r > 6'h01) begin
                    cntNxt = cnt_r - 6'h01; // R07
                end else if (tc[`EBPS_TC_RDYEN] && !rdyActive) begin
                    cntNxt = 6'h01; // R07
                end else begin
                    capture = !write_r; // R09
                    if (lenF != 6'h00) begin
                        phaseNxt = PH_F;
                        cntNxt = lenF;
                    end else begin
                        phaseNxt = PH_IDLE; // R13
                        cntNxt = 6'h00;
                    end
                end
            end
            PH_F: begin
                if (cnt_r > 6'h01) begin
                    cntNxt = cnt_r - 6'h01;
                end else begin
                    phaseNxt = PH_IDLE;
                    cntNxt = 6'h00;
                end
            end
            default: begin
                phaseNxt = PH_IDLE;
                cntNxt = 6'h00;
            end
        endcase
    end

    // ----------------------------------------
    // sequencer state and pins
    // ----------------------------------------
    // pins follow the phase being entered, so they are flop outputs
    always @(posedge clk) begin
        if (!reset_n) begin
            phase_r <= PH_IDLE;
            cnt_r <= 6'h00;
            lastCs_r <= {CS_W{1'b0}};
            curCs_r <= {CS_W{1'b0}};
            write_r <= 1'b0;
            rdata_r <= {DATA_W{1'b0}};
            rspValid <= 1'b0;
            rspRdata <= {DATA_W{1'b0}};
            busAddr <= {ADDR_W{1'b0}};
            busDataOut <= {DATA_W{1'b0}};
            busDataOe <= 1'b0;
            busCs_n <= {NUM_CS{1'b1}};
            busAle <= 1'b0;
            busRd_n <= 1'b1;
            busWr_n <= 1'b1;
        end else if (ce) begin
            phase_r <= phaseNxt;
            cnt_r <= cntNxt;
            rspValid <= 1'b0;
            // latch the cycle's attributes on start
            if (phase_r == PH_IDLE && reqValid) begin
                curCs_r <= reqCs;
                lastCs_r <= reqCs; // R04
                write_r <= reqWrite;
                busAddr <= reqAddr;
                busDataOut <= reqWdata;
            end
            // read data taken on the edge that ends the strobe
            if (capture) begin
                rdata_r <= dinS2_r; // R09
                rspRdata <= dinS2_r;
            end
            // completion pulse on return to idle
            if (phase_r != PH_IDLE && phaseNxt == PH_IDLE) begin
                rspValid <= 1'b1;
            end
            // chip select over the whole cycle, one-hot
            busCs_n <= {NUM_CS{1'b1}};
            if (phaseNxt != PH_IDLE) begin
                busCs_n[(phase_r == PH_IDLE) ? reqCs : curCs_r] <= 1'b0;
            end
            busAle <= (phaseNxt == PH_AB);
            // strobes only during access
            busRd_n <= !(phaseNxt == PH_E && !((phase_r == PH_IDLE) ? reqWrite : write_r));
            busWr_n <= !(phaseNxt == PH_E && write_r);
            // write data from D through hold
            busDataOe <= write_r && (phaseNxt == PH_D || phaseNxt == PH_E || phaseNxt == PH_F);
        end
    end

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    // one wait state: ack one cycle after the strobe, then dropped
    assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always @(posedge clk) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            extClkDrvEn <= `EBPS_CTRL_RST;
        end else if (ce) begin
            wb_ack_o <= wbReq;
            wb_dat_o <= 32'h0000_0000;
            if (wbReq && !wb_we_i) begin
                // unmapped addresses read as zero
                if (wb_adr_i == `EBPS_OFS_CTRL) begin
                    wb_dat_o <= {31'h0000_0000, extClkDrvEn};
                end else if (wb_adr_i == `EBPS_OFS_STATUS) begin
                    wb_dat_o <= {24'h00_0000, lastCs_r, 1'b0, phase_r, 1'b0, phase_r != PH_IDLE};
                end else if (wb_adr_i == `EBPS_OFS_RDATA) begin
                    wb_dat_o <= {{(32-DATA_W){1'b0}}, rdata_r};
                end
            end
            if (wbReq && wb_we_i && wb_sel_i[0] && wb_adr_i == `EBPS_OFS_CTRL) begin
                extClkDrvEn <= wb_dat_i[`EBPS_CTRL_CLKDRV]; // R08
            end
            if (wbReq && !wb_we_i) begin
                if (wb_adr_i >= `EBPS_OFS_TCFG0 && wb_adr_i < `EBPS_OFS_TCFG0 + NUM_CS * `EBPS_TCFG_STRIDE
                    && wb_adr_i[1:0] == 2'b00) begin
                    wb_dat_o <= {16'h0000, tcfg_r[wb_adr_i[CS_W+1:2]]};
                end
            end
        end
    end

    // ----------------------------------------
    // timing config registers, one per chip select
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CS; gi = gi + 1) begin : gTcfg
            // written low byte and high byte by lane
            always @(posedge clk) begin
                if (!reset_n) begin
                    tcfg_r[gi] <= `EBPS_TC_RST;
                end else if (ce && wbReq && wb_we_i
                    && wb_adr_i == `EBPS_OFS_TCFG0 + gi * `EBPS_TCFG_STRIDE) begin
                    if (wb_sel_i[0]) begin
                        tcfg_r[gi][7:0] <= wb_dat_i[7:0]; // R02
                    end
                    if (wb_sel_i[1]) begin
                        tcfg_r[gi][15:8] <= wb_dat_i[15:8];
                    end
                end
            end
        end
    endgenerate

endmodule

/* ebps_asserts.sv */
// ebps_asserts.sv: port-level timing checks on the bus phase sequencer.
// assumes: bound into ebps_sequencer; one clk domain, sync reset_n.
`timescale 1ns/1ps
module ebps_asserts #(
    parameter NUM_CS = 4
) (
    // clock, reset, enable
    input wire clk,
    input wire reset_n,
    input wire ce,
    // wishbone
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    // core side
    input wire reqReady,
    input wire rspValid,
    // bus pins
    input wire [NUM_CS-1:0] busCs_n,
    input wire busAle,
    input wire busRd_n,
    input wire busWr_n,
    input wire busDataOe,
    input wire busRefClkOut
);
    // ------------------------------
    // properties
    // ------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
        else $error("ack missing");
    chk_ref_clk: assert property (@(negedge clk) disable iff (!reset_n) busRefClkOut)
        else $error("ref clock low while clk high");
    chk_ale_len: assert property ($rose(busAle) |-> ##[1:5] !busAle)
        else $error("address setup too long");
    chk_ale_order: assert property (busAle |-> busRd_n && busWr_n)
        else $error("strobe during address setup");
    chk_strobe_excl: assert property (!(!busRd_n && !busWr_n))
        else $error("read and write strobes together");
    chk_idle_cs: assert property (reqReady |-> &busCs_n)
        else $error("chip select low while idle");
    chk_rsp_end: assert property (rspValid |-> &busCs_n && busRd_n && busWr_n ##1 !rspValid)
        else $error("response before cycle end");
    chk_access_len: assert property ($fell(busRd_n) |-> ##[1:45] busRd_n)
        else $error("access phase too long");
    chk_write_oe: assert property (!busWr_n |-> busDataOe && !(&busCs_n))
        else $error("write strobe without data drive");
endmodule

bind ebps_sequencer ebps_asserts #(.NUM_CS(NUM_CS)) ebps_asserts_inst (.clk(clk), .reset_n(reset_n), .ce(ce),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .reqReady(reqReady),
    .rspValid(rspValid), .busCs_n(busCs_n), .busAle(busAle), .busRd_n(busRd_n), .busWr_n(busWr_n),
    .busDataOe(busDataOe), .busRefClkOut(busRefClkOut));

/* ebps_mem_model.sv */
// ebps_mem_model.sv: sixteen-word external memory with a ready handshake.
// assumes: pins sampled on clk; ready level and wait count set by the bench.
`timescale 1ns/1ps
module ebps_mem_model (
    // clock
    input wire clk,
    // bus pins
    input wire [3:0] busAddr,
    input wire [15:0] busDataOut,
    input wire busCs_n,
    input wire busRd_n,
    input wire busWr_n,
    // ready setup
    input wire rdyPol,
    input wire [1:0] waits,
    // answers
    output wire [15:0] busDataIn,
    output wire busReady
);
    reg [15:0] mem [0:15]; // storage
    reg [15:0] lastOut = 16'h0000; // last value driven
    reg [2:0] cnt = 3'h0; // cycles into the strobe
    wire strobe = !busRd_n || !busWr_n; // access under way
    integer i;
    initial begin
        for (i = 0; i < 16; i = i + 1)
            mem[i] = 16'h0000;
    end
    // data while selected for reading, inverse of it once released
    assign busDataIn = (!busCs_n && busWr_n) ? mem[busAddr] : ~lastOut;
    // active only inside the strobe, so it is gone before the next cycle
    assign busReady = (strobe && cnt >= {1'b0, waits}) ? rdyPol : ~rdyPol;
    // ------------------------------
    // storage and strobe counter
    // ------------------------------
    always @(posedge clk) begin
        if (!busCs_n && busWr_n)
            lastOut <= mem[busAddr];
        if (!busCs_n && !busWr_n)
            mem[busAddr] <= busDataOut;
        cnt <= strobe ? cnt + {2'h0, cnt < 3'h4} : 3'h0;
    end
endmodule

/* external_bus_phase_sequencer_tb.sv */
// external_bus_phase_sequencer_tb.sv: random bus cycles against a memory model.
// assumes: default sequencer parameters; 50 MHz clk.
`timescale 1ns/1ps
module external_bus_phase_sequencer_tb;
    reg clk = 1'b0; // system clock
    reg reset_n = 1'b0; // sync reset
    reg wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0; // wishbone strobes
    reg [7:0] wbAdr = 8'h00;
    reg [31:0] wbDat = 32'h0, q, r, seed = 32'h3c;
    reg reqValid = 1'b0, reqWrite = 1'b0, rdyPol = 1'b0;
    reg [1:0] reqCs = 2'h0, waits = 2'h0, lastCs = 2'h0;
    reg [23:0] reqAddr = 24'h0;
    reg [15:0] reqWdata = 16'h0, tc, phase_time_unit [0:3], shadow [0:15];
    wire [31:0] wbDatO;
    wire [15:0] rspRdata, busDataOut, busDataIn;
    wire [23:0] busAddr;
    wire [3:0] busCs_n;
    wire wbAck, reqReady, rspValid, busDataOe, busAle, busRd_n, busWr_n, busReady, busRefClkOut, extClkDrvEn;
    integer fail_count = 0, checks = 0, csLow, strLow, aleHigh, i, n, ab;
    always #10 clk = ~clk;
    ebps_sequencer ebps_sequencer_inst (.clk(clk), .reset_n(reset_n), .ce(1'b1), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
        .reqCs(reqCs), .reqAddr(reqAddr), .reqWdata(reqWdata), .rspValid(rspValid), .rspRdata(rspRdata),
        .busAddr(busAddr), .busDataOut(busDataOut), .busDataOe(busDataOe), .busDataIn(busDataIn),
        .busCs_n(busCs_n), .busAle(busAle), .busRd_n(busRd_n), .busWr_n(busWr_n), .busReady(busReady),
        .busRefClkOut(busRefClkOut), .extClkDrvEn(extClkDrvEn));
    ebps_mem_model ebps_mem_model_inst (.clk(clk), .busAddr(busAddr[3:0]), .busDataOut(busDataOut),
        .busCs_n(&busCs_n), .busRd_n(busRd_n), .busWr_n(busWr_n), .rdyPol(rdyPol), .waits(waits),
        .busDataIn(busDataIn), .busReady(busReady));
    // ------------------------------
    // helpers
    // ------------------------------
    function [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        xs = seed;
    endfunction
    task check(input [31:0] seen, input [31:0] exp, input string what);
        checks = checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one classic single wishbone cycle, held until ack
    task wb(input we, input [7:0] adr, input [31:0] dat);
        @(posedge clk);
        {wbCyc, wbStb, wbWe, wbAdr, wbDat} <= {2'b11, we, adr, dat};
        n = 0;
        do begin
            @(posedge clk);
            n = n + 1;
        end while (wbAck !== 1'b1 && n < 50);
        q = wbDatO;
        {wbCyc, wbStb} <= 2'b00;
        check(n < 50, 1, "register ack");
    endtask
    // phase counts seen on the pins since the request was taken
    always @(posedge clk) begin
        if (reqValid && reqReady) begin
            csLow = 0;
            strLow = 0;
            aleHigh = 0;
        end else begin
            csLow = csLow + !(&busCs_n);
            strLow = strLow + (!busRd_n || !busWr_n);
            aleHigh = aleHigh + busAle;
        end
    end
    // one bus cycle, fields drawn from v, shape checked against the config
    task run(input [31:0] v);
        tc = phase_time_unit[v[17:16]];
        @(posedge clk);
        {rdyPol, waits} <= {tc[14], v[24:23]};
        {reqValid, reqWrite, reqCs, reqAddr, reqWdata} <= {1'b1, v[18], v[17:16], v[31:12], v[22:19], v[7:0],
            v[31:24]};
        do @(posedge clk);
        while (reqReady !== 1'b1);
        reqValid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1 n = n + 1;
        end while (rspValid !== 1'b1 && n < 200);
        check(rspValid, 1, "cycle done");
        ab = (tc[0] ? 2 : 1) + (v[17:16] != lastCs ? tc[2:1] : 0);
        check(aleHigh, ab, "setup");
        check(csLow - strLow, ab + tc[4:3] + tc[5] + tc[12:11], "phases");
        if (tc[13])
            check(strLow >= tc[10:6] + 1, 1, "ready access");
        else
            check(strLow, tc[10:6] + 1, "access");
        if (!v[18])
            check(rspRdata, shadow[v[22:19]], "read data");
        else
            shadow[v[22:19]] = {v[7:0], v[31:24]};
        lastCs = v[17:16];
    endtask
    // ------------------------------
    // main sequence and watchdog
    // ------------------------------
    initial begin
        #400000 fail_count = fail_count + 1;
        stop_test();
    end
    initial begin
        for (i = 0; i < 16; i = i + 1)
            {phase_time_unit[i % 4], shadow[i]} = {16'h07df, 16'h0000};
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        wb(1'b0, 8'h10, 32'h0);
        check(q, 32'h07df, "timing reset");
        wb(1'b0, 8'h00, 32'h0);
        check(q, 32'h1, "ctrl reset");
        wb(1'b1, 8'h00, 32'h0);
        @(posedge clk);
        #1 check(extClkDrvEn, 1'b0, "driver off");
        wb(1'b1, 8'h00, 32'h1);
        wb(1'b0, 8'hfc, 32'h0);
        check(q, 32'h0, "unmapped");
        check(busRefClkOut, clk, "ref clock");
        for (i = 0; i < 40; i = i + 1) begin
            r = xs();
            if (i < 2 || r[31]) begin
                phase_time_unit[r[17:16]] = (i == 0) ? 16'h0000 : (i == 1) ? 16'h1fff : r[15:0];
                wb(1'b1, 8'h10 + {4'h0, r[17:16], 2'b00}, {16'h0, phase_time_unit[r[17:16]]});
            end
            run(r);
        end
        stop_test();
    end
endmodule
